// ---- inc/dec_conv_pkg.sv ----
// constants and types shared by the decimal conversion and negate unit
package dec_conv_pkg;
	localparam logic [7:0]  OP_SINGLE_TO_DEC = 8'h18;        // code 024 decimal
	localparam logic [7:0]  OP_DOUBLE_TO_DEC = 8'h3b;        // code 059 decimal
	localparam logic [7:0]  OP_TWOS_COMP     = 8'ha0;        // code 160 decimal
	localparam logic [15:0] SINGLE_LIMIT     = 16'h270f;
	localparam logic [31:0] DOUBLE_LIMIT     = 32'h05f5e0ff;
	localparam int          SIGN_BIT         = 15;
	localparam logic [15:0] RESULT_RESET     = 16'h0000;
	localparam logic [6:0]  DONE_STEP        = 7'h21;         // 32 shift steps then finish

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE  = 3'b100
	} conv_state_t;
endpackage

// ---- verilog/dec_conv_unit.sv ----
// binary to decimal conversion and two's complement datapath
`timescale 1ns/1ps
`default_nettype none
module dec_conv_unit
	import dec_conv_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        exec_stb,
	input  wire logic [7:0]  op_code,
	input  wire logic [15:0] src_lo,
	input  wire logic [15:0] src_hi,
	output logic      [15:0] result_lo,
	output logic      [15:0] result_hi,
	output logic             error_flag,
	output logic             equals_flag,
	output logic             negative_flag,
	output logic             done,
	output logic             busy
);
	// add 3 to every digit of five or more before each shift
	function automatic logic [31:0] digit_adjust(input logic [31:0] v);
		logic [31:0] r;
		r = v;
		for (int i = 0; i < 8; i++) begin
			if (r[i*4 +: 4] > 4'h4) begin
				r[i*4 +: 4] = r[i*4 +: 4] + 4'h3;
			end
		end
		return r;
	endfunction

	conv_state_t state_reg, state_next;
	logic [31:0] bin_reg, bin_next;
	logic [31:0] dec_reg, dec_next;
	logic [6:0]  step_reg, step_next;
	logic        dbl_reg, dbl_next;
	logic        err_reg, err_next;
	logic [15:0] rlo_reg, rlo_next, rhi_reg, rhi_next;
	logic        eq_reg, eq_next, neg_reg, neg_next, done_reg, done_next;
	logic [15:0] negated;
	logic [31:0] adj;
	logic        busy_next;

	assign negated = ~src_lo + 16'h0001;
	assign adj     = digit_adjust(dec_reg);

	// serial double-dabble: 32 cycles for both widths keeps one datapath
	always_comb begin
		state_next = state_reg;
		bin_next   = bin_reg;
		dec_next   = dec_reg;
		step_next  = step_reg;
		dbl_next   = dbl_reg;
		err_next   = err_reg;
		rlo_next   = rlo_reg;
		rhi_next   = rhi_reg;
		eq_next    = eq_reg;
		neg_next   = neg_reg;
		done_next  = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (exec_stb) begin
					if (op_code == OP_TWOS_COMP) begin
						rlo_next  = negated;
						neg_next  = negated[SIGN_BIT];
						err_next  = 1'b0;
						eq_next   = (negated == 16'h0000);
						done_next = 1'b1;
					end else if (op_code == OP_SINGLE_TO_DEC) begin
						// zero-extended so both widths share the 32-step count
						bin_next   = {16'h0000, src_lo};
						dbl_next   = 1'b0;
						err_next   = (src_lo > SINGLE_LIMIT);
						dec_next   = 32'h0;
						step_next  = 7'h0;
						state_next = ST_SHIFT;
					end else if (op_code == OP_DOUBLE_TO_DEC) begin
						bin_next   = {src_hi, src_lo};
						dbl_next   = 1'b1;
						err_next   = ({src_hi, src_lo} > DOUBLE_LIMIT);
						dec_next   = 32'h0;
						step_next  = 7'h0;
						state_next = ST_SHIFT;
					end
				end
			end
			ST_SHIFT: begin
				{dec_next, bin_next} = {adj, bin_reg} << 1;
				step_next = step_reg + 7'h01;
				if (step_reg == DONE_STEP - 7'h02) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				// out-of-range inputs still produce the low digits that fit
				rlo_next   = dec_reg[15:0];
				rhi_next   = dbl_reg ? dec_reg[31:16] : rhi_reg;
				eq_next    = dbl_reg ? (dec_reg == 32'h0) : (dec_reg[15:0] == 16'h0);
				neg_next   = 1'b0;
				done_next  = 1'b1;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
		// busy drops with the done cycle so a new strobe is taken right after
		busy_next = (state_next != ST_IDLE);
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			bin_reg   <= 32'h0;
			dec_reg   <= 32'h0;
			step_reg  <= 7'h0;
			dbl_reg   <= 1'b0;
			err_reg   <= 1'b0;
			rlo_reg   <= RESULT_RESET;
			rhi_reg   <= RESULT_RESET;
			eq_reg    <= 1'b0;
			neg_reg   <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			bin_reg   <= bin_next;
			dec_reg   <= dec_next;
			step_reg  <= step_next;
			dbl_reg   <= dbl_next;
			err_reg   <= err_next;
			rlo_reg   <= rlo_next;
			rhi_reg   <= rhi_next;
			eq_reg    <= eq_next;
			neg_reg   <= neg_next;
			done_reg  <= done_next;
		end
	end

	logic busy_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= busy_next;
		end
	end

	assign result_lo     = rlo_reg;
	assign result_hi     = rhi_reg;
	assign error_flag    = err_reg;
	assign equals_flag   = eq_reg;
	assign negative_flag = neg_reg;
	assign done          = done_reg;
	assign busy          = busy_reg;

	// checks
	// only an idle accept is a request: strobes during a conversion are dropped
	a_neg_result: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_TWOS_COMP) |=>
		done && result_lo == 16'h0000 - $past(src_lo)) else $error("negate result wrong");
	a_neg_8000: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_TWOS_COMP && src_lo == 16'h8000) |=>
		result_lo == 16'h8000 && !error_flag) else $error("8000 negate wrong");
	a_neg_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_TWOS_COMP) |=>
		negative_flag == result_lo[15] && !error_flag) else $error("negate flags wrong");
	a_neg_equals: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_TWOS_COMP) |=>
		equals_flag == (result_lo == 16'h0)) else $error("negate equals wrong");
	a_single_err: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_SINGLE_TO_DEC) |=>
		error_flag == ($past(src_lo) > 16'h270f)) else $error("single error wrong");
	a_double_err: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_DOUBLE_TO_DEC) |=>
		error_flag == ({$past(src_hi), $past(src_lo)} > 32'h05f5e0ff)) else $error("double error wrong");
	a_single_val: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_SINGLE_TO_DEC && src_lo == 16'h04d2) |=>
		##[1:40] done ##0 result_lo == 16'h1234) else $error("single conversion wrong");
	a_double_val: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_DOUBLE_TO_DEC && {src_hi, src_lo} == 32'h00bc614e) |=>
		##[1:40] done ##0 (result_hi == 16'h1234 && result_lo == 16'h5678)) else $error("double wrong");
	a_conv_equals: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_DONE) |=> equals_flag == (dbl_reg ? {result_hi, result_lo} == 32'h0
		: result_lo == 16'h0)) else $error("conversion equals wrong");
	a_conv_time: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_DOUBLE_TO_DEC) |=> ##33 done)
		else $error("conversion latency wrong");
	a_single_time: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code == OP_SINGLE_TO_DEC) |=> ##33 done)
		else $error("single latency wrong");
	a_busy_conv: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && (op_code == OP_SINGLE_TO_DEC || op_code == OP_DOUBLE_TO_DEC)) |=>
		busy) else $error("busy missing during conversion");
	a_done_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
		done |-> !busy) else $error("busy still high at completion");
	a_conv_neg_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_DONE) |=> !negative_flag) else $error("negative flag after conversion");
	a_hi_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		((state_reg == ST_DONE && !dbl_reg) ||
		(state_reg == ST_IDLE && exec_stb && op_code == OP_TWOS_COMP)) |=>
		$stable(result_hi)) else $error("high result word disturbed");
	a_refused_strobe: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_SHIFT && exec_stb) |=> $stable(error_flag) && !done) else $error("busy strobe taken");
	a_conv_err_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_DONE) |=> $stable(error_flag)) else $error("error flag moved at completion");
	a_unknown_op: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_IDLE && exec_stb && op_code != OP_TWOS_COMP && op_code != OP_SINGLE_TO_DEC
		&& op_code != OP_DOUBLE_TO_DEC) |=> !done && !busy) else $error("unknown code acted on");
	c_single: cover property (@(posedge ref_clk) state_reg == ST_DONE && !dbl_reg);
	c_double: cover property (@(posedge ref_clk) state_reg == ST_DONE && dbl_reg);
	c_negate: cover property (@(posedge ref_clk) exec_stb && op_code == OP_TWOS_COMP && state_reg == ST_IDLE);
	c_error:  cover property (@(posedge ref_clk) error_flag && done);
endmodule // dec_conv_unit
`default_nettype wire

// ---- tb/seq_model.sv ----
// instruction sequencer stand-in that issues one execute request per go pulse
`timescale 1ns/1ps
`default_nettype none
module seq_model (
	input  wire logic        ref_clk,
	input  wire logic        go,
	input  wire logic [7:0]  op_in,
	input  wire logic [31:0] val_in,
	output logic             exec_stb,
	output logic      [7:0]  op_code,
	output logic      [31:0] src
);
	initial begin
		exec_stb = 1'b0;
		op_code  = 8'h00;
		src      = 32'h0;
	end
	// operands scramble once released so nothing relies on stale words
	always @(posedge ref_clk) begin
		exec_stb <= go;
		op_code  <= go ? op_in : ~op_code;
		src      <= go ? val_in : ~src;
	end
endmodule // seq_model
`default_nettype wire

// ---- tb/dec_conv_unit_tb.sv ----
// self-checking bench for the decimal conversion and negate unit
`timescale 1ns/1ps
`default_nettype none
module dec_conv_unit_tb;
	import dec_conv_pkg::*;
	logic        ref_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic        go      = 1'b0;
	logic [7:0]  op_in   = 8'h00;
	logic [31:0] val_in  = 32'h0;
	wire         exec_stb, error_flag, equals_flag, negative_flag, done, busy;
	wire [7:0]   op_code;
	wire [31:0]  src;
	wire [15:0]  result_lo, result_hi;
	int          fails = 0;
	int          n_tests = 0;
	logic        timed_out = 1'b0;
	logic [15:0] last_hi   = 16'h0000;
	logic [39:0] q[$];
	always #50 ref_clk = ~ref_clk;
	seq_model seq (.ref_clk(ref_clk), .go(go), .op_in(op_in), .val_in(val_in), .exec_stb(exec_stb),
		.op_code(op_code), .src(src));
	dec_conv_unit dut (.ref_clk(ref_clk), .resetn(resetn), .exec_stb(exec_stb), .op_code(op_code),
		.src_lo(src[15:0]), .src_hi(src[31:16]), .result_lo(result_lo), .result_hi(result_hi),
		.error_flag(error_flag), .equals_flag(equals_flag), .negative_flag(negative_flag), .done(done), .busy(busy));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// reference digits built with plain integer division
	function automatic logic [31:0] to_dec(input longint v, input int n);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < n; i++) begin
			r[4*i +: 4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction
	task automatic run(input logic [7:0] op, input logic [31:0] v);
		logic [31:0] e;
		logic        er;
		logic        b;
		logic        conv;
		int          k;
		conv = (op === OP_SINGLE_TO_DEC || op === OP_DOUBLE_TO_DEC);
		b    = 1'b0;
		@(posedge ref_clk);
		go     <= 1'b1;
		op_in  <= op;
		val_in <= v;
		@(posedge ref_clk);
		go <= 1'b0;
		for (k = 0; k < 60 && done !== 1'b1; k++) begin
			@(posedge ref_clk);
			// extra strobe mid-conversion must be ignored
			go <= (k == 2) && conv;
			#1;
			if (k == 0) b = busy;
		end
		chk(b, conv);
		if (!conv && op !== OP_TWOS_COMP) begin
			chk(done, 1'b0);
		end else if (done !== 1'b1) begin
			fails++;
			timed_out = 1'b1;
			$display("[FAIL] %0t no completion", $time);
		end else begin
			if (op === OP_TWOS_COMP) begin
				e  = {16'h0, 16'(~v[15:0] + 16'h1)};
				er = 1'b0;
			end else if (op === OP_SINGLE_TO_DEC) begin
				e  = to_dec(longint'(v[15:0]) % 10000, 4);
				er = v[15:0] > SINGLE_LIMIT;
			end else begin
				e  = to_dec(longint'(v) % 100000000, 8);
				er = v > DOUBLE_LIMIT;
			end
			chk(result_lo, e[15:0]);
			chk(result_hi, op === OP_DOUBLE_TO_DEC ? e[31:16] : last_hi);
			if (op === OP_DOUBLE_TO_DEC) last_hi = e[31:16];
			chk(error_flag, er);
			chk(equals_flag, e == 32'h0);
			chk(negative_flag, op === OP_TWOS_COMP && e[15]);
			chk(busy, 1'b0);
		end
		$display("test op %h src %h finished", op, v);
	endtask
	initial begin
		void'($urandom(32'h05de84b7));
		q = '{{OP_TWOS_COMP, 32'h0}, {OP_TWOS_COMP, 32'h8000}, {OP_TWOS_COMP, 32'h1}, {OP_TWOS_COMP, 32'h7fff},
			{OP_SINGLE_TO_DEC, 32'h0}, {OP_SINGLE_TO_DEC, 32'h270f}, {OP_SINGLE_TO_DEC, 32'h2710},
			{OP_SINGLE_TO_DEC, 32'hffff}, {OP_DOUBLE_TO_DEC, 32'h0}, {OP_DOUBLE_TO_DEC, 32'h05f5e0ff},
			{OP_DOUBLE_TO_DEC, 32'h05f5e100}, {OP_DOUBLE_TO_DEC, 32'hffffffff}, {8'h55, 32'h1234},
			{OP_SINGLE_TO_DEC, 32'h000004d2}, {OP_DOUBLE_TO_DEC, 32'h00bc614e}};
		for (int i = 0; i < 18; i++) begin
			q.push_back({i % 3 == 0 ? OP_TWOS_COMP : i % 3 == 1 ? OP_SINGLE_TO_DEC : OP_DOUBLE_TO_DEC,
				i % 2 == 1 ? $urandom() : $urandom() % 32'd12000});
		end
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk({result_hi, result_lo}, 32'h0);
		chk({error_flag, equals_flag, negative_flag, done, busy}, 32'h0);
		foreach (q[i]) if (!timed_out) run(q[i][39:32], q[i][31:0]);
		report_and_stop();
	end
endmodule // dec_conv_unit_tb
`default_nettype wire
